// ---- rtl/tec_cfg_regs.sv ----
// configuration register bank of a thermoelectric-cooler driver with its serial slave
// assumes: all pins synchronous to CLOCK; analogue comparators arrive as levels
// Behaviour
// - every register is eight bits, bit 0 least significant.
// - slave address 0x21 with strap low, 0x60 with strap floating.
// - control bit 7 picks monitor quantity, 1 current, resets 1.
// - control bit 4 picks discharge 60 ms or 30 ms, resets 1.
// - control bits 3:2 pick soft-start 120/60/30/15 ms, reset 00.
// - writing 1 to control bit 1 releases latched flags, self-clears.
// - control bit 0 gates the power stage, resets 1.
// - current-limit bit 7 enables heating/cooling current cap, resets enabled.
// - voltage-limit bit 7 enables heating/cooling voltage cap, resets enabled.
// - current code is 39 mA per step, codes above 0x34 reserved.
// - current codes reset to 100110, 1482 mA.
// - voltage code is 97.6 mV per step, codes above 0x39 reserved.
// - voltage codes reset to 011100, 2732.8 mV.
// - heating voltage register bit 6 enables input over-voltage guard.
// - linear-leg thresholds at 7:6 and 5:4, 2 to 3.5 A.
// - switching-leg thresholds at 3:2 and 1:0, 2.5 to 4 A.
// - any leg overcurrent beyond threshold while the stage runs enters hiccup protection.
// - codes unsigned; read-write bits read back, read-only bits not written.
// - limit and temperature flags stay set until refresh.
// - stage runs only with supply ok, enable, shutdown high and control bit.
// - mode status 00 boundary, 01 cooling, 10 heating selects limit set.
`timescale 1ns/100ps
module tec_cfg_regs
  import tec_cfg_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       SRST,
  input  wire logic       CE,
  input  wire logic       ADDR_STRAP_LOW,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       SUPPLY_OK,
  input  wire logic       EN_PIN,
  input  wire logic       SD_PIN,
  input  wire logic [1:0] MODE_STATUS,
  input  wire logic       VLIM_HIT,
  input  wire logic       LEG_OVERCURRENT_THRESHOLDS_HIT,
  input  wire logic       OT_HIT,
  input  wire logic       OTW_HIT,
  input  wire logic       LEG_OVERCURRENT,
  output logic            MONITOR_CURRENT_SEL,
  output logic [7:0]      DISCHARGE_MS,
  output logic [7:0]      SOFT_START_MS,
  output logic            STAGE_RUN,
  output logic            CURRENT_CAP_EN,
  output logic [5:0]      CURRENT_CAP_CODE,
  output logic            VOLTAGE_CAP_EN,
  output logic [5:0]      VOLTAGE_CAP_CODE,
  output logic            INPUT_OVERVOLTAGE_GUARD_EN,
  output logic [1:0]      LINEAR_LEG_THRESHOLD,
  output logic [1:0]      SWITCH_LEG_THRESHOLD,
  output logic            HICCUP_REQ,
  output logic [3:0]      LATCHED_FLAGS,
  output logic [6:0]      SLAVE_ADDR
);
  logic [7:0] regs_r [NUM_REGS];
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic       strap_r;
  logic       refresh_r;
  logic       hiccup_r;
  tec_serial_bus_if bus ();

  // strap sampled every enabled cycle, reset does not gate it
  always_ff @(posedge CLOCK)
  begin
    if (CE) strap_r <= ADDR_STRAP_LOW;
  end
  // the port shadows the package constant of the same name, hence the scoped reference
  assign SLAVE_ADDR = strap_r ? tec_cfg_pkg::ADDR_STRAP_LOW : ADDR_STRAP_FLOAT;

  tec_serial_slave u_slave (
    .clock    (CLOCK),
    .srst     (SRST),
    .ce       (CE),
    .own_addr (SLAVE_ADDR),
    .scl_in   (SCL_IN),
    .sda_in   (SDA_IN),
    .sda_oe   (SDA_OE),
    .bus      (bus.slave)
  );
  assign SDA_OUT = 1'b0;

  wire       wr_hit    = bus.wr_stb & (bus.offset < 8'(NUM_REGS));
  wire [2:0] wr_idx    = bus.offset[2:0];
  wire       refresh_w = wr_hit & (wr_idx == OFF_CONTROL) & bus.wdata[BIT_REFRESH];
  wire [7:0] ctrl      = regs_r[OFF_CONTROL];
  wire [7:0] oc        = regs_r[OFF_LEG_OC];
  wire       heat      = (MODE_STATUS == MODE_HEAT);

  // refresh reads back as zero; stored bit always cleared
  assign bus.rdata = (bus.offset < 8'(NUM_REGS)) ? regs_r[bus.offset[2:0]] : 8'h00;

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      regs_r[OFF_CONTROL]   <= RST_CONTROL;
      regs_r[OFF_HEAT_LEG_OVERCURRENT_THRESHOLDS] <= RST_LEG_OVERCURRENT_THRESHOLDS;
      regs_r[OFF_COOL_LEG_OVERCURRENT_THRESHOLDS] <= RST_LEG_OVERCURRENT_THRESHOLDS;
      regs_r[OFF_HEAT_VLIM] <= RST_HEAT_VLIM;
      regs_r[OFF_COOL_VLIM] <= RST_COOL_VLIM;
      regs_r[OFF_LEG_OC]    <= RST_LEG_OC;
    end
    else if (CE && wr_hit)
    begin
      regs_r[wr_idx] <= (wr_idx == OFF_CONTROL) ? (bus.wdata & ~(8'h01 << BIT_REFRESH)) : bus.wdata;
    end
  end

  // set wins over the refresh release
  always_comb
  begin
    flags_nxt = refresh_r ? 4'h0 : flags_r;
    flags_nxt[STAT_VLIM] = flags_nxt[STAT_VLIM] | VLIM_HIT;
    flags_nxt[STAT_LEG_OVERCURRENT_THRESHOLDS] = flags_nxt[STAT_LEG_OVERCURRENT_THRESHOLDS] | LEG_OVERCURRENT_THRESHOLDS_HIT;
    flags_nxt[STAT_OT]   = flags_nxt[STAT_OT] | OT_HIT;
    flags_nxt[STAT_OTW]  = flags_nxt[STAT_OTW] | OTW_HIT;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      flags_r <= 4'h0; refresh_r <= 1'b0; hiccup_r <= 1'b0;
    end
    else if (CE)
    begin
      flags_r   <= flags_nxt;
      refresh_r <= refresh_w;
      hiccup_r  <= LEG_OVERCURRENT & STAGE_RUN;
    end
  end
  assign LATCHED_FLAGS = flags_r;
  assign HICCUP_REQ    = hiccup_r;

  assign MONITOR_CURRENT_SEL = ctrl[BIT_MONITOR];
  assign DISCHARGE_MS = ctrl[BIT_DISCHARGE] ? 8'(DISCHARGE_SHORT_MS) : 8'(DISCHARGE_LONG_MS);
  assign SOFT_START_MS = (ctrl[BIT_SS_HI:BIT_SS_LO] == 2'h0) ? 8'(SS0_MS) :
                         (ctrl[BIT_SS_HI:BIT_SS_LO] == 2'h1) ? 8'(SS1_MS) :
                         (ctrl[BIT_SS_HI:BIT_SS_LO] == 2'h2) ? 8'(SS2_MS) : 8'(SS3_MS);
  assign STAGE_RUN = SUPPLY_OK & EN_PIN & SD_PIN & ctrl[BIT_STAGE_ON];
  wire [7:0] ireg = heat ? regs_r[OFF_HEAT_LEG_OVERCURRENT_THRESHOLDS] : regs_r[OFF_COOL_LEG_OVERCURRENT_THRESHOLDS];
  wire [7:0] vreg = heat ? regs_r[OFF_HEAT_VLIM] : regs_r[OFF_COOL_VLIM];
  // reserved codes clamp to the top legal step
  assign CURRENT_CAP_EN   = ireg[BIT_CAP_EN];
  assign CURRENT_CAP_CODE = (ireg[5:0] > LEG_OVERCURRENT_THRESHOLDS_CODE_MAX) ? LEG_OVERCURRENT_THRESHOLDS_CODE_MAX : ireg[5:0];
  assign VOLTAGE_CAP_EN   = vreg[BIT_CAP_EN];
  assign VOLTAGE_CAP_CODE = (vreg[5:0] > VLIM_CODE_MAX) ? VLIM_CODE_MAX : vreg[5:0];
  assign INPUT_OVERVOLTAGE_GUARD_EN = regs_r[OFF_HEAT_VLIM][BIT_OVP_EN];
  assign LINEAR_LEG_THRESHOLD = heat ? oc[7:6] : oc[5:4];
  assign SWITCH_LEG_THRESHOLD = heat ? oc[3:2] : oc[1:0];

  property p_flag_sticky;
    @(posedge CLOCK) disable iff (SRST) (CE && VLIM_HIT) |=> flags_r[STAT_VLIM];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("vlim flag not set");
  property p_flag_hold;
    @(posedge CLOCK) disable iff (SRST) (CE && flags_r[STAT_OT] && !refresh_r) |=> flags_r[STAT_OT];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without refresh");
  property p_refresh_clears;
    @(posedge CLOCK) disable iff (SRST) (CE && refresh_w) ##1 (CE && !OTW_HIT) |=> !flags_r[STAT_OTW];
  endproperty
  a_refresh_clears: assert property (p_refresh_clears) else $error("refresh did not release");
  property p_refresh_self;
    @(posedge CLOCK) disable iff (SRST) !regs_r[OFF_CONTROL][BIT_REFRESH];
  endproperty
  a_refresh_self: assert property (p_refresh_self) else $error("refresh bit stuck");
  property p_stage;
    @(posedge CLOCK) disable iff (SRST) STAGE_RUN |-> (SUPPLY_OK && EN_PIN && SD_PIN && ctrl[0]);
  endproperty
  a_stage: assert property (p_stage) else $error("stage ran without all conditions");
  property p_icap;
    @(posedge CLOCK) disable iff (SRST) CURRENT_CAP_CODE <= LEG_OVERCURRENT_THRESHOLDS_CODE_MAX;
  endproperty
  a_icap: assert property (p_icap) else $error("current code reserved");
  property p_vcap;
    @(posedge CLOCK) disable iff (SRST) VOLTAGE_CAP_CODE <= VLIM_CODE_MAX;
  endproperty
  a_vcap: assert property (p_vcap) else $error("voltage code reserved");
  property p_hiccup;
    @(posedge CLOCK) disable iff (SRST) (CE && LEG_OVERCURRENT && STAGE_RUN) |=> HICCUP_REQ;
  endproperty
  a_hiccup: assert property (p_hiccup) else $error("hiccup missed");
  property p_write;
    @(posedge CLOCK) disable iff (SRST) (CE && wr_hit && wr_idx == OFF_LEG_OC) |=> oc == $past(bus.wdata);
  endproperty
  a_write: assert property (p_write) else $error("write not stored");
  c_write: cover property (@(posedge CLOCK) CE && wr_hit);
  c_refresh: cover property (@(posedge CLOCK) refresh_w);
  c_hiccup: cover property (@(posedge CLOCK) HICCUP_REQ);
  c_read: cover property (@(posedge CLOCK) bus.rd_stb);
endmodule

// ---- rtl/tec_cfg_pkg.sv ----
// constants for the cooler-driver configuration bank and its serial slave
// assumes: one 40 MHz clock, synchronous active-high reset
package tec_cfg_pkg;
  localparam int          CLK_MHZ           = 40;
  localparam logic [2:0]  OFF_CONTROL       = 3'h0;
  localparam logic [2:0]  OFF_HEAT_LEG_OVERCURRENT_THRESHOLDS     = 3'h1;
  localparam logic [2:0]  OFF_COOL_LEG_OVERCURRENT_THRESHOLDS     = 3'h2;
  localparam logic [2:0]  OFF_HEAT_VLIM     = 3'h3;
  localparam logic [2:0]  OFF_COOL_VLIM     = 3'h4;
  localparam logic [2:0]  OFF_LEG_OC        = 3'h5;
  localparam int          NUM_REGS          = 6;
  localparam logic [7:0]  RST_CONTROL       = 8'h91;
  localparam logic [7:0]  RST_LEG_OVERCURRENT_THRESHOLDS          = 8'hA6;
  localparam logic [7:0]  RST_HEAT_VLIM     = 8'hDC;
  localparam logic [7:0]  RST_COOL_VLIM     = 8'h9C;
  localparam logic [7:0]  RST_LEG_OC        = 8'h00;
  localparam int          BIT_MONITOR       = 7;
  localparam int          BIT_DISCHARGE     = 4;
  localparam int          BIT_SS_HI         = 3;
  localparam int          BIT_SS_LO         = 2;
  localparam int          BIT_REFRESH       = 1;
  localparam int          BIT_STAGE_ON      = 0;
  localparam int          BIT_CAP_EN        = 7;
  localparam int          BIT_OVP_EN        = 6;
  localparam logic [5:0]  LEG_OVERCURRENT_THRESHOLDS_CODE_MAX     = 6'h34;
  localparam logic [5:0]  VLIM_CODE_MAX     = 6'h39;
  localparam int          LEG_OVERCURRENT_THRESHOLDS_STEP_MA      = 39;
  localparam int          VLIM_STEP_UV      = 97600;
  localparam logic [6:0]  ADDR_STRAP_LOW    = 7'h21;
  localparam logic [6:0]  ADDR_STRAP_FLOAT  = 7'h60;
  localparam int          DISCHARGE_LONG_MS = 60;
  localparam int          DISCHARGE_SHORT_MS = 30;
  localparam int          SS0_MS            = 120;
  localparam int          SS1_MS            = 60;
  localparam int          SS2_MS            = 30;
  localparam int          SS3_MS            = 15;
  localparam int          MS_CYCLES         = CLK_MHZ * 1000;
  localparam logic [1:0]  MODE_BOUNDARY     = 2'h0;
  localparam logic [1:0]  MODE_COOL         = 2'h1;
  localparam logic [1:0]  MODE_HEAT         = 2'h2;
  localparam int          STAT_VLIM         = 3;
  localparam int          STAT_LEG_OVERCURRENT_THRESHOLDS         = 2;
  localparam int          STAT_OT           = 1;
  localparam int          STAT_OTW          = 0;
endpackage

// ---- rtl/tec_serial_bus_if.sv ----
// carrier between serial slave and register bank
// assumes: single clock domain
`timescale 1ns/100ps
interface tec_serial_bus_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] offset;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output wr_stb, output rd_stb, output offset, output wdata, input rdata);
  modport bank  (input wr_stb, input rd_stb, input offset, input wdata, output rdata);
endinterface

// ---- rtl/tec_serial_slave.sv ----
// two-wire serial slave: offset byte then data bytes, reads from current offset
// assumes: bus lines synchronous to CLOCK, sampled each enabled cycle
`timescale 1ns/100ps
module tec_serial_slave
  import tec_cfg_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic [6:0] own_addr,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe,
  tec_serial_bus_if.slave bus
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_ADDR = 5'b00010, S_ACK = 5'b00100, S_RX = 5'b01000, S_TX = 5'b10000
  } slv_state_t;
  slv_state_t state_r;
  logic [7:0] shift_r;
  logic [3:0] cnt_r;
  logic       scl_r;
  logic       sda_r;
  logic       rw_r;
  logic       have_off_r;
  logic       ack_drv_r;
  logic       tx_bit_r;
  logic [7:0] off_r;
  logic       wr_r;
  logic       rd_r;
  wire rise  = scl_in & ~scl_r;
  wire fall  = ~scl_in & scl_r;
  wire start = scl_in & sda_r & ~sda_in;
  wire stop  = scl_in & ~sda_r & sda_in;
  wire addr_hit = (shift_r[7:1] == own_addr);
  assign bus.offset = off_r;
  assign bus.wdata  = shift_r;
  assign bus.wr_stb = wr_r;
  assign bus.rd_stb = rd_r;
  assign sda_oe     = ack_drv_r | ((state_r == S_TX) & ~tx_bit_r);
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r <= S_IDLE; shift_r <= 8'h00; cnt_r <= 4'h0; scl_r <= 1'b1; sda_r <= 1'b1;
      rw_r <= 1'b0; have_off_r <= 1'b0; ack_drv_r <= 1'b0; tx_bit_r <= 1'b1;
      off_r <= 8'h00; wr_r <= 1'b0; rd_r <= 1'b0;
    end
    else if (ce)
    begin
      scl_r <= scl_in;
      sda_r <= sda_in;
      wr_r  <= 1'b0;
      rd_r  <= 1'b0;
      if (start)
      begin
        state_r <= S_ADDR; cnt_r <= 4'h0; have_off_r <= 1'b0; ack_drv_r <= 1'b0;
      end
      else if (stop)
      begin
        state_r <= S_IDLE; ack_drv_r <= 1'b0;
      end
      else
        case (state_r)
          S_IDLE: ;
          S_ADDR, S_RX:
            if (rise)
            begin
              shift_r <= {shift_r[6:0], sda_in};
              cnt_r   <= cnt_r + 4'h1;
            end
            else if (fall && cnt_r == 4'h8)
            begin
              cnt_r <= 4'h0;
              if (state_r == S_ADDR)
              begin
                // address mismatch drops out until the next start
                if (addr_hit)
                begin
                  ack_drv_r <= 1'b1; rw_r <= shift_r[0]; state_r <= S_ACK;
                  if (shift_r[0]) rd_r <= 1'b1;
                end
                else
                  state_r <= S_IDLE;
              end
              else
              begin
                ack_drv_r <= 1'b1; state_r <= S_ACK;
                if (!have_off_r)
                begin
                  off_r <= shift_r; have_off_r <= 1'b1;
                end
                else
                  wr_r <= 1'b1;
              end
            end
          S_ACK:
            if (fall)
            begin
              ack_drv_r <= 1'b0;
              if (rw_r)
              begin
                state_r <= S_TX; shift_r <= {bus.rdata[6:0], 1'b0}; tx_bit_r <= bus.rdata[7];
                cnt_r <= 4'h1;
              end
              else
                state_r <= S_RX;
            end
          S_TX:
            if (fall)
            begin
              if (cnt_r == 4'h8)
              begin
                // one byte per read; the master's acknowledge bit is not looked at
                tx_bit_r <= 1'b1; cnt_r <= 4'h0;
                off_r <= off_r + 8'h01;
                state_r <= S_IDLE;
              end
              else
              begin
                tx_bit_r <= shift_r[7]; shift_r <= {shift_r[6:0], 1'b0}; cnt_r <= cnt_r + 4'h1;
              end
            end
          default: state_r <= S_IDLE;
        endcase
      if (wr_r) off_r <= off_r + 8'h01;
    end
  end

  // a data-line move while the clock is high would read as a start or stop
  property p_sda_steady;
    @(posedge clock) disable iff (srst) (ce && $changed(sda_oe)) |-> !scl_in;
  endproperty
  a_sda_steady: assert property (p_sda_steady) else $error("data line moved while clock high");
endmodule

// ---- bench/tec_host_model.sv ----
// two-wire host model: open-drain master of the serial pins
// assumes: bench resolves the data wire with a pull-up, slave samples on clock
`timescale 1ns/100ps
module tec_host_model (
  input  wire logic clock,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_o
);
  // slow bit phases so the synchronous slave sees every level change
  localparam int HALF = 4;

  initial
  begin
    scl   = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask

  // data changes only while clock is low; wire level taken at end of high phase
  task automatic put_bit(input logic b, output logic seen);
    sda_o = b;
    wait_n(HALF);
    scl = 1'b1;
    wait_n(HALF);
    seen = sda_line;
    scl = 1'b0;
  endtask

  task automatic start();
    sda_o = 1'b1;
    scl   = 1'b1;
    wait_n(HALF);
    sda_o = 1'b0;
    wait_n(HALF);
    scl = 1'b0;
  endtask

  task automatic stop();
    sda_o = 1'b0;
    wait_n(HALF);
    scl = 1'b1;
    wait_n(HALF);
    sda_o = 1'b1;
    wait_n(HALF);
  endtask

  // msb first, ninth bit released for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  // host leaves the line released and answers with no acknowledge
  task automatic get_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(1'b1, s);
  endtask

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] off, input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start();
    send_byte({addr, 1'b0}, a0);
    send_byte(off, a1);
    send_byte(data, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // offset set by a write cycle, then one byte read from it
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] off, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    send_byte({addr, 1'b0}, a0);
    send_byte(off, a1);
    stop();
    start();
    send_byte({addr, 1'b1}, a2);
    get_byte(d);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// ---- bench/test_tec_cfg_regs.sv ----
// self-checking bench for the cooler-driver configuration bank
// assumes: host model on the serial pins, 40 MHz clock, clock enable held high
`timescale 1ns/100ps
module test_tec_cfg_regs;
  import tec_cfg_pkg::*;
  localparam int LIMIT = 60000;
  logic       clock, srst, strap_low, supply_ok, en_pin, sd_pin, leg_oc, scl, sda_host, ok;
  logic [1:0] mode, lin_thr, sw_thr;
  logic [3:0] hits, flags;
  logic       monitor_sel, stage_run, cur_en, volt_en, ovp_en, hiccup, sda_oe;
  logic [7:0] discharge_ms, soft_start_ms;
  logic [5:0] cur_code, volt_code;
  logic [6:0] slave_addr, addr_now;
  wire        sda_line;
  int         fail_count, compares, cycles;
  int         ss_tab [4] = '{SS0_MS, SS1_MS, SS2_MS, SS3_MS};
  logic [7:0] rst_tab [6] = '{8'h91, 8'hA6, 8'hA6, 8'hDC, 8'h9C, 8'h00};

  assign sda_line = sda_host & ~sda_oe;

  tec_cfg_regs dut (
    .CLOCK(clock), .SRST(srst), .CE(1'b1), .ADDR_STRAP_LOW(strap_low), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(), .SDA_OE(sda_oe), .SUPPLY_OK(supply_ok), .EN_PIN(en_pin), .SD_PIN(sd_pin), .MODE_STATUS(mode),
    .VLIM_HIT(hits[3]), .LEG_OVERCURRENT_THRESHOLDS_HIT(hits[2]), .OT_HIT(hits[1]), .OTW_HIT(hits[0]), .LEG_OVERCURRENT(leg_oc),
    .MONITOR_CURRENT_SEL(monitor_sel), .DISCHARGE_MS(discharge_ms), .SOFT_START_MS(soft_start_ms),
    .STAGE_RUN(stage_run), .CURRENT_CAP_EN(cur_en), .CURRENT_CAP_CODE(cur_code), .VOLTAGE_CAP_EN(volt_en),
    .VOLTAGE_CAP_CODE(volt_code), .INPUT_OVERVOLTAGE_GUARD_EN(ovp_en), .LINEAR_LEG_THRESHOLD(lin_thr),
    .SWITCH_LEG_THRESHOLD(sw_thr), .HICCUP_REQ(hiccup), .LATCHED_FLAGS(flags), .SLAVE_ADDR(slave_addr)
  );

  tec_host_model u_host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_o(sda_host));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] data);
    u_host.write_reg(addr_now, off, data, ok);
    check("write ack", 8'h01, 8'(ok));
  endtask

  task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] d;
    u_host.read_reg(addr_now, off, d, ok);
    check("read ack", 8'h01, 8'(ok));
    check("read data", exp, d);
  endtask

  // decoded caps seen through the mode-selected set
  task automatic caps(input logic [7:0] cur, input logic [7:0] volt, input logic [7:0] thr);
    @(negedge clock);
    check("current cap", cur, {cur_en, 1'b0, cur_code});
    check("voltage cap", volt, {volt_en, 1'b0, volt_code});
    check("leg thresholds", thr, {4'h0, lin_thr, sw_thr});
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    {srst, strap_low, supply_ok, en_pin, sd_pin, leg_oc} = 6'b101110;
    {mode, hits, addr_now} = {MODE_HEAT, 4'h0, ADDR_STRAP_FLOAT};
    repeat (2) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    check("slave addr", 8'(ADDR_STRAP_FLOAT), 8'(slave_addr));
    check("monitor sel", 8'h01, 8'(monitor_sel));
    check("discharge", 8'(DISCHARGE_SHORT_MS), discharge_ms);
    check("stage run", 8'h01, 8'(stage_run));
    check("ovp enable", 8'h01, 8'(ovp_en));
    check("current cap", 8'hA6, {cur_en, 1'b0, cur_code});
    check("voltage cap", 8'h9C, {volt_en, 1'b0, volt_code});
    for (int i = 0; i < NUM_REGS; i++)
      rd_chk(8'(i), rst_tab[i]);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 8'(i << 2));
      check("soft start", 8'(ss_tab[i]), soft_start_ms);
    end
    check("discharge", 8'(DISCHARGE_LONG_MS), discharge_ms);
    check("monitor sel", 8'h00, 8'(monitor_sel));
    check("stage run", 8'h00, 8'(stage_run));
    rd_chk(8'h00, 8'h0C);
    // every flag latches past its event, refresh releases all
    hits = 4'hF;
    @(negedge clock);
    hits = 4'h0;
    repeat (2) @(negedge clock);
    check("latched flags", 8'h0F, 8'(flags));
    wr(8'h00, 8'h63);
    check("latched flags", 8'h00, 8'(flags));
    rd_chk(8'h00, 8'h61);
    for (int i = 0; i < 3; i++)
    begin
      {supply_ok, en_pin, sd_pin} = ~(3'b001 << i);
      @(negedge clock);
      check("stage gate", 8'h00, 8'(stage_run));
    end
    leg_oc = 1'b1;
    repeat (2) @(negedge clock);
    check("hiccup idle", 8'h00, 8'(hiccup));
    {supply_ok, en_pin, sd_pin} = 3'b111;
    @(negedge clock);
    check("hiccup", 8'h01, 8'(hiccup));
    leg_oc = 1'b0;
    // top legal codes only, the host never writes reserved ones
    wr(8'h01, 8'h34);
    wr(8'h02, 8'hB4);
    wr(8'h03, 8'h39);
    wr(8'h04, 8'hB9);
    wr(8'h05, 8'h6C);
    caps(8'h34, 8'h39, 8'h07);
    check("ovp enable", 8'h00, 8'(ovp_en));
    mode = MODE_COOL;
    caps(8'hB4, 8'hB9, 8'h08);
    mode = MODE_BOUNDARY;
    caps(8'hB4, 8'hB9, 8'h08);
    rd_chk(8'h02, 8'hB4);
    rd_chk(8'h05, 8'h6C);
    u_host.write_reg(addr_now, 8'h06, 8'h55, ok);
    rd_chk(8'h06, 8'h00);
    strap_low = 1'b1;
    repeat (2) @(negedge clock);
    check("slave addr", 8'(ADDR_STRAP_LOW), 8'(slave_addr));
    u_host.write_reg(addr_now, 8'h00, 8'h00, ok);
    check("old address ignored", 8'h00, 8'(ok));
    addr_now = ADDR_STRAP_LOW;
    rd_chk(8'h00, 8'h61);
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    rd_chk(8'h05, 8'h00);
    close_out();
  end
endmodule
